/* steer_pkg.sv */
/*
   Constants and types for the waveform output steering block.
   Assumes an AXI4-Lite master on a 100 MHz clock with synchronous active-low reset.
*/
package steer_pkg;
   localparam logic [11:0] OFFSET_STEER_CONTROL = 12'h000;
   localparam logic [11:0] OFFSET_POLARITY = 12'h004;
   localparam logic [11:0] OFFSET_RISE_DEADBAND = 12'h008;
   localparam logic [11:0] OFFSET_FALL_DEADBAND = 12'h00C;
   localparam logic [11:0] OFFSET_MODE = 12'h010;
   localparam int POLARITY_IN_BIT = 5;
   localparam int DEADBAND_WIDTH = 6;
   localparam int PIN_COUNT = 4;
   localparam int STEER_FIXED_LSB = 4;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [3:0] POLARITY_RESET = 4'h0;
   localparam logic [7:0] STEER_RESET = 8'h00;
   localparam logic [5:0] DEADBAND_RESET = 6'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_STEER_ASYNC = 3'h0,
      MODE_STEER_SYNC = 3'h1,
      MODE_OTHER = 3'h7
   } mode_type;

   typedef struct packed {
      logic [3:0] fixed_level;
      logic [3:0] enable;
   } steer_type;
endpackage

/* steer_output_stage.sv */
/*
   Output stage: turns the active steer selection into four pin levels.
   Assumes all inputs are synchronous to aclk.
*/
`timescale 1ns/1ps
module steer_output_stage (
   // Selection and data
   input wire logic data_in,
   input wire steer_pkg::steer_type steer,
   input wire logic [3:0] polarity,
   input wire logic shutdown,
   input wire logic [3:0] shutdown_level,
   // Pins
   output logic [3:0] pin_out
);
   always_comb begin
      for (int i = 0; i < steer_pkg::PIN_COUNT; i++) begin
         if (!steer.enable[i]) begin
            pin_out[i] = steer.fixed_level[i];
         end else if (shutdown) begin
            pin_out[i] = shutdown_level[i];
         end else begin
            pin_out[i] = data_in ^ polarity[i];
         end
      end
   end
endmodule

/* waveform_output_steering.sv */
/*
   Output steering top: AXI4-Lite registers, steering update timing, pins.
   Assumes data_in and shutdown_event come from pins or another domain.
*/
`timescale 1ns/1ps
module waveform_output_steering (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Waveform side
   input wire logic data_in,
   input wire logic shutdown_event,
   input wire logic [3:0] shutdown_level,
   output logic [3:0] waveform_output_pins,
   output logic [2:0] mode,
   output logic [5:0] rise_deadband_value,
   output logic [5:0] fall_deadband_value
);
   logic [1:0] data_sync;
   logic [1:0] shut_sync;
   logic data_prev;
   logic have_aw, have_w, next_have_aw, next_have_w;
   logic [11:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   steer_pkg::steer_type steer_written, next_steer_written;
   steer_pkg::steer_type steer_active, next_steer_active;
   logic pending, next_pending;
   logic [3:0] polarity, next_polarity;
   logic [2:0] next_mode;
   logic [5:0] next_rise, next_fall;
   logic data_rise, do_write;
   logic [3:0] pins_comb;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == steer_pkg::OFFSET_STEER_CONTROL) || (a == steer_pkg::OFFSET_POLARITY)
         || (a == steer_pkg::OFFSET_RISE_DEADBAND) || (a == steer_pkg::OFFSET_FALL_DEADBAND)
         || (a == steer_pkg::OFFSET_MODE);
   endfunction

   // Input synchronisers; the first stage feeds only the second.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_sync <= 2'h0;
         shut_sync <= 2'h0;
         data_prev <= 1'b0;
      end else begin
         data_sync <= {data_sync[0], data_in};
         shut_sync <= {shut_sync[0], shutdown_event};
         data_prev <= data_sync[1];
      end
   end
   assign data_rise = data_sync[1] & ~data_prev;

   assign s_axi_awready = !have_aw && !s_axi_bvalid;
   assign s_axi_wready = !have_w && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = have_aw && have_w && !s_axi_bvalid;

   always_comb begin
      next_have_aw = have_aw;
      next_have_w = have_w;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      next_steer_written = steer_written;
      next_steer_active = steer_active;
      next_pending = pending;
      next_polarity = polarity;
      next_mode = mode;
      next_rise = rise_deadband_value;
      next_fall = fall_deadband_value;
      if (s_axi_awvalid && s_axi_awready) begin
         next_have_aw = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_have_w = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // Synchronous mode moves the pending selection across on an input rise.
      if (pending && data_rise) begin
         next_steer_active = steer_written;
         next_pending = 1'b0;
      end
      if (do_write) begin
         next_have_aw = 1'b0;
         next_have_w = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = addr_known(aw_addr) ? steer_pkg::RESP_OKAY : steer_pkg::RESP_SLVERR;
         if (w_strb[0]) begin
            if (aw_addr == steer_pkg::OFFSET_STEER_CONTROL) begin
               next_steer_written = w_data[7:0];
               if (mode == steer_pkg::MODE_STEER_SYNC) begin
                  next_pending = 1'b1;
               end else begin
                  next_steer_active = w_data[7:0];
                  next_pending = 1'b0;
               end
            end else if (aw_addr == steer_pkg::OFFSET_POLARITY) begin
               next_polarity = w_data[3:0];
            end else if (aw_addr == steer_pkg::OFFSET_RISE_DEADBAND) begin
               next_rise = w_data[5:0];
            end else if (aw_addr == steer_pkg::OFFSET_FALL_DEADBAND) begin
               next_fall = w_data[5:0];
            end else if (aw_addr == steer_pkg::OFFSET_MODE) begin
               next_mode = w_data[2:0];
               if (w_data[2:0] != steer_pkg::MODE_STEER_SYNC && pending) begin
                  next_steer_active = steer_written;
                  next_pending = 1'b0;
               end
            end
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = steer_pkg::RESP_OKAY;
         next_rdata = 32'h00000000;
         if (s_axi_araddr == steer_pkg::OFFSET_STEER_CONTROL) begin
            next_rdata[7:0] = steer_written;
         end else if (s_axi_araddr == steer_pkg::OFFSET_POLARITY) begin
            next_rdata[3:0] = polarity;
            next_rdata[steer_pkg::POLARITY_IN_BIT] = data_sync[1];
         end else if (s_axi_araddr == steer_pkg::OFFSET_RISE_DEADBAND) begin
            next_rdata[5:0] = rise_deadband_value;
         end else if (s_axi_araddr == steer_pkg::OFFSET_FALL_DEADBAND) begin
            next_rdata[5:0] = fall_deadband_value;
         end else if (s_axi_araddr == steer_pkg::OFFSET_MODE) begin
            next_rdata[2:0] = mode;
            next_rdata[3] = pending;
         end else begin
            next_rresp = steer_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= steer_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= steer_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         steer_written <= steer_pkg::STEER_RESET;
         steer_active <= steer_pkg::STEER_RESET;
         pending <= 1'b0;
         polarity <= steer_pkg::POLARITY_RESET;
         mode <= steer_pkg::MODE_RESET;
         rise_deadband_value <= steer_pkg::DEADBAND_RESET;
         fall_deadband_value <= steer_pkg::DEADBAND_RESET;
      end else begin
         have_aw <= next_have_aw;
         have_w <= next_have_w;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         steer_written <= next_steer_written;
         steer_active <= next_steer_active;
         pending <= next_pending;
         polarity <= next_polarity;
         mode <= next_mode;
         rise_deadband_value <= next_rise;
         fall_deadband_value <= next_fall;
      end
   end

   steer_output_stage stage (
      .data_in(data_sync[1]),
      .steer(steer_active),
      .polarity(polarity),
      .shutdown(shut_sync[1]),
      .shutdown_level(shutdown_level),
      .pin_out(pins_comb)
   );

   // Pins are registered so they come from flip-flops.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         waveform_output_pins <= 4'h0;
      end else begin
         waveform_output_pins <= pins_comb;
      end
   end

   sequence write_async_s;
      do_write && w_strb[0] && aw_addr == steer_pkg::OFFSET_STEER_CONTROL
         && mode == steer_pkg::MODE_STEER_ASYNC;
   endsequence
   sequence write_sync_s;
      do_write && w_strb[0] && aw_addr == steer_pkg::OFFSET_STEER_CONTROL
         && mode == steer_pkg::MODE_STEER_SYNC && !(pending && data_rise);
   endsequence

   async_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
      write_async_s |=> steer_active == $past(w_data[7:0]))
      else $error("async steer write not applied");
   sync_pending_a: assert property (@(posedge aclk) disable iff (!aresetn)
      write_sync_s |=> pending)
      else $error("sync steer write not pending");
   sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pending && !data_rise && !do_write) |=> $stable(steer_active))
      else $error("steer changed before input rise");
   sync_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pending && data_rise && !do_write) |=> steer_active == $past(steer_written) && !pending)
      else $error("pending steer not applied on rise");
   fixed_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !steer_active.enable[0] |=> waveform_output_pins[0] == $past(steer_active.fixed_level[0]))
      else $error("fixed level not held");
   steer_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (steer_active.enable[1] && !shut_sync[1])
         |=> waveform_output_pins[1] == $past(data_sync[1] ^ polarity[1]))
      else $error("steered pin wrong");
   shutdown_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (steer_active.enable[2] && shut_sync[1])
         |=> waveform_output_pins[2] == $past(shutdown_level[2]))
      else $error("shutdown level not driven");
   input_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == steer_pkg::OFFSET_POLARITY)
         |=> s_axi_rdata[5] == $past(data_sync[1]) && s_axi_rdata[31:6] == 26'h0000000)
      else $error("input level readback wrong");
   deadband_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && w_strb[0] && aw_addr == steer_pkg::OFFSET_RISE_DEADBAND)
         |=> rise_deadband_value == $past(w_data[5:0]))
      else $error("rise dead-band not stored");
endmodule

/* tb_top.sv */
/*
   Self-checking bench for the waveform output steering block: registers, steering, shutdown.
   Assumes steer_pkg and the design modules are compiled before this file.
*/
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb_top;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic data_in = 1'h0, shutdown_event = 1'h0;
   logic [3:0] shutdown_level = 4'h0, waveform_output_pins;
   logic [2:0] mode;
   logic [5:0] rise_deadband_value, fall_deadband_value;
   int failures = 0, comparisons = 0;

   always #5 aclk = ~aclk;

   waveform_output_steering dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .data_in, .shutdown_event, .shutdown_level,
      .waveform_output_pins, .mode, .rise_deadband_value, .fall_deadband_value
   );

   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
      logic aw, w, b;
      int n;
      aw = 1'h0;
      w = 1'h0;
      b = 1'h0;
      n = 0;
      // One edge between calls keeps a new request off the edge that ended the last one.
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!b && n < 50) begin
         @(posedge aclk);
         n++;
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         if (s_axi_bvalid) begin
            b = 1'h1;
            resp = s_axi_bresp;
         end
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
         s_axi_bready <= !b;
      end
      if (!b) failures++;
   endtask

   task automatic axi_read(input logic [11:0] a);
      logic ar, done;
      int n;
      ar = 1'h0;
      done = 1'h0;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!done && n < 50) begin
         @(posedge aclk);
         n++;
         ar = ar | s_axi_arready;
         if (s_axi_rvalid) begin
            done = 1'h1;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
         end
         s_axi_arvalid <= !ar;
         s_axi_rready <= !done;
      end
      if (!done) failures++;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      axi_read(a);
      `CHECK("read data", exp, rd)
   endtask

   // Pins follow the input through a synchroniser, so the check waits for them to settle.
   task automatic pins_chk(input logic [7:0] s, input logic [3:0] pol, input logic d,
         input logic sd, input logic [3:0] lvl);
      logic [3:0] drive;
      repeat (6) @(posedge aclk);
      drive = sd ? lvl : ({4{d}} ^ pol);
      `CHECK("pins", (s[3:0] & drive) | (~s[3:0] & s[7:4]), waveform_output_pins)
   endtask

   task automatic test_registers();
      rd_chk(steer_pkg::OFFSET_RISE_DEADBAND, 32'h00000000);
      axi_write(steer_pkg::OFFSET_RISE_DEADBAND, 32'hFFFFFFFF);
      rd_chk(steer_pkg::OFFSET_RISE_DEADBAND, 32'h0000003F);
      `CHECK("rise value", 6'h3F, rise_deadband_value)
      // A write without the low byte strobe leaves the register alone.
      s_axi_wstrb <= 4'hE;
      axi_write(steer_pkg::OFFSET_RISE_DEADBAND, 32'h00000000);
      s_axi_wstrb <= 4'hF;
      `CHECK("masked write resp", steer_pkg::RESP_OKAY, resp)
      `CHECK("masked rise value", 6'h3F, rise_deadband_value)
      axi_write(steer_pkg::OFFSET_FALL_DEADBAND, 32'h12345695);
      rd_chk(steer_pkg::OFFSET_FALL_DEADBAND, 32'h00000015);
      `CHECK("fall value", 6'h15, fall_deadband_value)
      axi_write(steer_pkg::OFFSET_POLARITY, 32'hFFFFFFFF);
      rd_chk(steer_pkg::OFFSET_POLARITY, 32'h0000000F);
      data_in <= 1'h1;
      repeat (4) @(posedge aclk);
      rd_chk(steer_pkg::OFFSET_POLARITY, 32'h0000002F);
      data_in <= 1'h0;
      repeat (4) @(posedge aclk);
      rd_chk(steer_pkg::OFFSET_POLARITY, 32'h0000000F);
      axi_write(12'h020, 32'h000000FF);
      `CHECK("write resp", steer_pkg::RESP_SLVERR, resp)
      axi_read(12'h020);
      `CHECK("read resp", steer_pkg::RESP_SLVERR, resp)
      $display("test registers done");
   endtask

   task automatic test_async();
      logic [7:0] cfg [4] = '{8'h0F, 8'hA5, 8'h53, 8'hF0};
      axi_write(steer_pkg::OFFSET_MODE, 32'h00000000);
      `CHECK("mode", 3'h0, mode)
      axi_write(steer_pkg::OFFSET_POLARITY, 32'h00000006);
      foreach (cfg[i]) begin
         axi_write(steer_pkg::OFFSET_STEER_CONTROL, {24'h000000, cfg[i]});
         for (int d = 0; d < 2; d++) begin
            data_in <= d[0];
            pins_chk(cfg[i], 4'h6, d[0], 1'h0, 4'h0);
         end
      end
      // The input stays high, so the new selection can only land without an input edge.
      axi_write(steer_pkg::OFFSET_STEER_CONTROL, 32'h00000090);
      pins_chk(8'h90, 4'h6, 1'h1, 1'h0, 4'h0);
      data_in <= 1'h0;
      $display("test async done");
   endtask

   task automatic test_sync();
      axi_write(steer_pkg::OFFSET_STEER_CONTROL, 32'h00000000);
      axi_write(steer_pkg::OFFSET_POLARITY, 32'h00000000);
      axi_write(steer_pkg::OFFSET_MODE, 32'h00000001);
      `CHECK("mode", 3'h1, mode)
      data_in <= 1'h1;
      repeat (4) @(posedge aclk);
      axi_write(steer_pkg::OFFSET_STEER_CONTROL, 32'h0000000F);
      pins_chk(8'h00, 4'h0, 1'h1, 1'h0, 4'h0);
      rd_chk(steer_pkg::OFFSET_MODE, 32'h00000009);
      data_in <= 1'h0;
      pins_chk(8'h00, 4'h0, 1'h0, 1'h0, 4'h0);
      data_in <= 1'h1;
      pins_chk(8'h0F, 4'h0, 1'h1, 1'h0, 4'h0);
      rd_chk(steer_pkg::OFFSET_MODE, 32'h00000001);
      // A pending selection lands at once when the mode leaves synchronous steering.
      axi_write(steer_pkg::OFFSET_STEER_CONTROL, 32'h00000050);
      pins_chk(8'h0F, 4'h0, 1'h1, 1'h0, 4'h0);
      axi_write(steer_pkg::OFFSET_MODE, 32'h00000000);
      pins_chk(8'h50, 4'h0, 1'h1, 1'h0, 4'h0);
      $display("test sync done");
   endtask

   task automatic test_shutdown();
      // Pins A to C are steered and D holds low, so only A to C may take the shutdown level.
      axi_write(steer_pkg::OFFSET_STEER_CONTROL, 32'h00000027);
      shutdown_level <= 4'hE;
      shutdown_event <= 1'h1;
      pins_chk(8'h27, 4'h0, 1'h1, 1'h1, 4'hE);
      shutdown_event <= 1'h0;
      pins_chk(8'h27, 4'h0, 1'h1, 1'h0, 4'hE);
      $display("test shutdown done");
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      report_and_stop();
   end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      test_registers();
      test_async();
      test_sync();
      test_shutdown();
      report_and_stop();
   end
endmodule
